// file: rtl/wdt_pkg.sv
// Package: register map, field positions, reset values and types of the watchdog
package wdt_pkg;
  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [11:0] OFS_CONTROL   = 12'h000;
  localparam logic [11:0] OFS_RESTART   = 12'h004;
  localparam logic [11:0] OFS_PROTECT   = 12'h008;
  localparam logic [11:0] OFS_MODE_ONE  = 12'h00C;
  localparam logic [11:0] OFS_MODE_TWO  = 12'h010;
  localparam logic [11:0] OFS_CLK_ONE   = 12'h014;
  localparam logic [11:0] OFS_CLK_TWO   = 12'h018;
  localparam logic [11:0] OFS_IRQ_STAT  = 12'h01C;
  localparam logic [11:0] OFS_IRQ_CLR   = 12'h020;
  localparam logic [11:0] OFS_IRQ_EN    = 12'h024;
  localparam logic [11:0] OFS_COUNT     = 12'h028;
  localparam logic [11:0] OFS_POWER     = 12'h02C;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BIT_DIV_SEL      = 7;
  localparam int BIT_UNLOCK       = 1;
  localparam int BIT_UFL_ACTION   = 2;
  localparam int BIT_CSP_SEL      = 2;
  localparam int BIT_STOP_REQ     = 0;
  localparam int BIT_SYSCLK_SEL   = 1;
  localparam int BIT_SUBCLK_CPU   = 0;
  localparam int BIT_WAIT_REQ     = 0;
  localparam int BIT_EV_UFL       = 0;
  localparam int BIT_EV_RESTART   = 1;
  // ************************************************************
  // Counts and reset values
  // ************************************************************
  localparam int          CNT_W     = 15;
  localparam int          DIV_FAST  = 16;
  localparam int          DIV_SLOW  = 128;
  localparam int          DIV_SUB   = 2;
  localparam logic [14:0] CNT_MAX   = 15'h7FFF;
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam int          EV_W      = 2;
  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RUN   = 2'b01,
    ST_FIRED = 2'b10
  } wdt_state_t;

  typedef struct packed {
    logic        stop_mode;
    logic        wait_mode;
    logic        sub_clk_cpu;
    logic        osc_tick;
  } sys_in_t;

  typedef struct packed {
    logic        irq;
    logic        wdt_reset;
    logic        osc_run;
    logic        stop_active;
  } sys_out_t;
endpackage : wdt_pkg

// file: rtl/wdt_prescaler.sv
// Prescaler: selectable divider producing one tick per division period
`timescale 1ns/1ps
`default_nettype none
module wdt_prescaler #(
  parameter int MAX_DIV = 128
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clear,
  input  wire logic       enable,
  input  wire logic [7:0] ratio,
  output logic            tick
);
  initial begin
    if (MAX_DIV < 2 || MAX_DIV > 256) $error("MAX_DIV out of range");
  end

  typedef struct packed {
    logic [7:0] cnt;
  } pre_state_t;

  pre_state_t st_q;
  pre_state_t st_d;

  always_comb begin
    st_d = st_q;
    tick = 1'b0;
    if (clear) begin
      st_d.cnt = 8'h00;
    end else if (enable) begin
      if (st_q.cnt >= ratio - 8'h01) begin
        st_d.cnt = 8'h00;
        tick     = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : wdt_prescaler
`default_nettype wire

// file: rtl/wdt_top.sv
// Watchdog timer with count source protective mode, APB register slave
// Contract
// RQ1: 15-bit down-counter ticked by CPU prescaler
// RQ2: Underflow gives interrupt or reset per action bit
// RQ3: Action bit sets only, locked until reset
// RQ4: Prescaler divides 16 or 128 per select
// RQ5: Sub clock CPU: divide by two always
// RQ6: Period equals ratio times 32768 cycles
// RQ7: Restart write reloads; first write starts counting
// RQ8: After reset prescaler and counter stay idle
// RQ9: Software restarts before period and in handler
// RQ10: Stop and wait freeze; resume from held value
// RQ11: Protective mode counts oscillator ticks directly
// RQ12: Protective entry sequence ends with restart write
// RQ13: Mode registers writable only while unlocked
// RQ14: Protective mode keeps oscillator running
// RQ15: Protective mode blocks stop request writes
// RQ16: Protective mode keeps counting in wait
// RQ17: Restart loads all ones, clears prescaler
// RQ18: Interrupt mode reloads; request one-cycle pulse
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module wdt_top (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire wdt_pkg::sys_in_t sys_in,
  output wdt_pkg::sys_out_t     sys_out,
  output logic                  irq
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    wdt_pkg::wdt_state_t fsm;
    logic [14:0]         cnt;
    logic                div_sel;
    logic                unlock;
    logic                ufl_action;
    logic                csp_sel;
    logic                stop_req;
    logic                sysclk_sel;
    logic                wdt_reset;
    logic                ufl_pulse;
    logic [1:0]          ev_stat;
    logic [1:0]          ev_en;
    logic [31:0]         rdata;
  } top_state_t;

  top_state_t st_q;
  top_state_t st_d;

  logic        wr_acc;
  logic        rd_acc;
  logic        restart_wr;
  logic        running;
  logic        freeze;
  logic        pre_tick;
  logic        cnt_step;
  logic [7:0]  ratio;
  logic [1:0]  ev_set;
  logic        addr_ok;

  assign wr_acc     = psel && penable && pwrite;
  assign rd_acc     = psel && !penable && !pwrite;
  assign restart_wr = wr_acc && (paddr == wdt_pkg::OFS_RESTART);                 // RQ7
  assign running    = (st_q.fsm != wdt_pkg::ST_IDLE);                              // RQ8
  // Protective mode ignores wait; stop cannot be entered then anyway
  assign freeze     = sys_in.stop_mode || (sys_in.wait_mode && !st_q.csp_sel);      // RQ10 RQ16

  // ************************************************************
  // Prescaler ratio
  // ************************************************************
  always_comb begin
    if (sys_in.sub_clk_cpu) begin
      ratio = 8'(wdt_pkg::DIV_SUB);                                                 // RQ5
    end else if (st_q.div_sel) begin
      ratio = 8'(wdt_pkg::DIV_SLOW);                                                // RQ4
    end else begin
      ratio = 8'(wdt_pkg::DIV_FAST);                                                // RQ4
    end
  end

  wdt_prescaler #(
    .MAX_DIV (wdt_pkg::DIV_SLOW)
  ) u_pre (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (restart_wr),                                                          // RQ17
    .enable  (running && !freeze && !st_q.csp_sel),                                 // RQ8
    .ratio   (ratio),
    .tick    (pre_tick)
  );

  // Oscillator tick bypasses the prescaler in protective mode
  assign cnt_step = running && !freeze && !restart_wr
                    && (st_q.csp_sel ? sys_in.osc_tick : pre_tick);                  // RQ1 RQ11 RQ6

  always_comb begin
    addr_ok = 1'b1;
    case (paddr)
      wdt_pkg::OFS_CONTROL, wdt_pkg::OFS_RESTART, wdt_pkg::OFS_PROTECT,
      wdt_pkg::OFS_MODE_ONE, wdt_pkg::OFS_MODE_TWO, wdt_pkg::OFS_CLK_ONE,
      wdt_pkg::OFS_CLK_TWO, wdt_pkg::OFS_IRQ_STAT, wdt_pkg::OFS_IRQ_CLR,
      wdt_pkg::OFS_IRQ_EN, wdt_pkg::OFS_COUNT, wdt_pkg::OFS_POWER: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    st_d           = st_q;
    st_d.ufl_pulse = 1'b0;
    ev_set         = 2'b00;
    // Counter
    if (restart_wr) begin
      st_d.cnt = wdt_pkg::CNT_MAX;                                                  // RQ17
      if (st_q.fsm == wdt_pkg::ST_IDLE) begin
        st_d.fsm = wdt_pkg::ST_RUN;                                                 // RQ7
      end
      ev_set[wdt_pkg::BIT_EV_RESTART] = 1'b1;
    end else if (cnt_step && st_q.fsm == wdt_pkg::ST_RUN) begin
      if (st_q.cnt == 15'h0000) begin
        ev_set[wdt_pkg::BIT_EV_UFL] = 1'b1;
        if (st_q.ufl_action) begin
          st_d.wdt_reset = 1'b1;                                                    // RQ2
          st_d.fsm       = wdt_pkg::ST_FIRED;
        end else begin
          st_d.ufl_pulse = 1'b1;                                                    // RQ2 RQ18
          st_d.cnt       = wdt_pkg::CNT_MAX;                                        // RQ18
        end
      end else begin
        st_d.cnt = st_q.cnt - 15'h0001;                                             // RQ1
      end
    end
    // Register writes
    if (wr_acc) begin
      case (paddr)
        wdt_pkg::OFS_CONTROL: st_d.div_sel = pwdata[wdt_pkg::BIT_DIV_SEL];
        wdt_pkg::OFS_PROTECT: st_d.unlock  = pwdata[wdt_pkg::BIT_UNLOCK];
        wdt_pkg::OFS_MODE_ONE: begin
          if (st_q.unlock && pwdata[wdt_pkg::BIT_UFL_ACTION]) begin                 // RQ13
            st_d.ufl_action = 1'b1;                                                 // RQ3
          end
        end
        wdt_pkg::OFS_MODE_TWO: begin
          if (st_q.unlock) begin                                                    // RQ13
            st_d.csp_sel = pwdata[wdt_pkg::BIT_CSP_SEL];
          end
        end
        wdt_pkg::OFS_CLK_ONE: begin
          if (!st_q.csp_sel) begin                                                  // RQ15
            st_d.stop_req = pwdata[wdt_pkg::BIT_STOP_REQ];
          end
        end
        wdt_pkg::OFS_CLK_TWO: st_d.sysclk_sel = pwdata[wdt_pkg::BIT_SYSCLK_SEL];
        wdt_pkg::OFS_IRQ_EN:  st_d.ev_en      = pwdata[1:0];
        default: begin
        end
      endcase
    end
    // Stop request is consumed once the system enters stop mode
    if (sys_in.stop_mode) begin
      st_d.stop_req = 1'b0;
    end
    // Set wins over clear
    if (wr_acc && paddr == wdt_pkg::OFS_IRQ_CLR) begin
      st_d.ev_stat = st_q.ev_stat & ~pwdata[1:0];
    end
    st_d.ev_stat = st_d.ev_stat | ev_set;
    // Read data captured in the setup cycle
    if (rd_acc) begin
      st_d.rdata = wdt_pkg::RST_WORD;
      case (paddr)
        wdt_pkg::OFS_CONTROL:  st_d.rdata[wdt_pkg::BIT_DIV_SEL]    = st_q.div_sel;
        wdt_pkg::OFS_PROTECT:  st_d.rdata[wdt_pkg::BIT_UNLOCK]     = st_q.unlock;
        wdt_pkg::OFS_MODE_ONE: st_d.rdata[wdt_pkg::BIT_UFL_ACTION] = st_q.ufl_action;
        wdt_pkg::OFS_MODE_TWO: st_d.rdata[wdt_pkg::BIT_CSP_SEL]    = st_q.csp_sel;
        wdt_pkg::OFS_CLK_ONE:  st_d.rdata[wdt_pkg::BIT_STOP_REQ]   = st_q.stop_req;
        wdt_pkg::OFS_CLK_TWO:  st_d.rdata[wdt_pkg::BIT_SYSCLK_SEL] = st_q.sysclk_sel;
        wdt_pkg::OFS_IRQ_STAT: st_d.rdata[1:0]                     = st_q.ev_stat;
        wdt_pkg::OFS_IRQ_EN:   st_d.rdata[1:0]                     = st_q.ev_en;
        wdt_pkg::OFS_COUNT:    st_d.rdata[14:0]                    = st_q.cnt;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign prdata              = st_q.rdata;
  assign pready              = 1'b1;
  assign pslverr             = psel && penable && !addr_ok;
  assign irq                 = |(st_q.ev_stat & st_q.ev_en);
  // One driver for the whole struct; oscillator also runs when picked as system clock
  assign sys_out = '{irq:         st_q.ufl_pulse,                                   // RQ18
                     wdt_reset:   st_q.wdt_reset,                                   // RQ2
                     osc_run:     st_q.csp_sel || st_q.sysclk_sel,                  // RQ14
                     stop_active: st_q.stop_req};                                   // RQ15

  // ************************************************************
  // Assertions
  // ************************************************************
  a_ufl_reset: assert property (@(posedge pclk) disable iff (!presetn)              // RQ2
    (cnt_step && st_q.fsm == wdt_pkg::ST_RUN && st_q.cnt == 15'h0000 && st_q.ufl_action)
      |=> sys_out.wdt_reset) else $error("Underflow did not raise reset");
  a_ufl_irq: assert property (@(posedge pclk) disable iff (!presetn)                // RQ18
    sys_out.irq |-> st_q.cnt == wdt_pkg::CNT_MAX ##1 !sys_out.irq)
    else $error("Interrupt pulse too long or no reload");
  a_action_lock: assert property (@(posedge pclk) disable iff (!presetn)            // RQ3
    st_q.ufl_action |=> st_q.ufl_action) else $error("Action bit cleared");
  a_mode_protect: assert property (@(posedge pclk) disable iff (!presetn)           // RQ13
    !st_q.unlock |=> $stable(st_q.csp_sel)) else $error("Mode write while locked");
  a_stop_block: assert property (@(posedge pclk) disable iff (!presetn)             // RQ15
    (st_q.csp_sel && !st_q.stop_req) |=> !st_q.stop_req) else $error("Stop entered");
  a_idle_hold: assert property (@(posedge pclk) disable iff (!presetn)              // RQ8
    (st_q.fsm == wdt_pkg::ST_IDLE && !restart_wr) |=> $stable(st_q.cnt))
    else $error("Counter moved while idle");
  a_restart_load: assert property (@(posedge pclk) disable iff (!presetn)           // RQ17
    restart_wr |=> st_q.cnt == wdt_pkg::CNT_MAX && running) else $error("Restart failed");
  a_freeze_hold: assert property (@(posedge pclk) disable iff (!presetn)            // RQ10
    (freeze && !restart_wr) |=> $stable(st_q.cnt)) else $error("Counted while frozen");
  a_osc_on: assert property (@(posedge pclk) disable iff (!presetn)                 // RQ14
    st_q.csp_sel |-> sys_out.osc_run) else $error("Oscillator off in protect");
  a_wait_count: assert property (@(posedge pclk) disable iff (!presetn)             // RQ16
    (st_q.csp_sel && sys_in.wait_mode && !sys_in.stop_mode && running
     && st_q.fsm == wdt_pkg::ST_RUN && sys_in.osc_tick && !restart_wr
     && st_q.cnt != 15'h0000) |=> st_q.cnt == $past(st_q.cnt) - 15'h0001)
    else $error("Protect mode froze in wait");
  c_irq:     cover property (@(posedge pclk) disable iff (!presetn) sys_out.irq);
  c_reset:   cover property (@(posedge pclk) disable iff (!presetn) sys_out.wdt_reset);
  c_protect: cover property (@(posedge pclk) disable iff (!presetn) st_q.csp_sel && restart_wr);
endmodule : wdt_top
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking testbench of the watchdog block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ************************************************************
  // Signals
  // ************************************************************
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [11:0]       paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  wdt_pkg::sys_in_t  sys_in;
  wdt_pkg::sys_out_t sys_out;
  logic              irq;
  logic              perr;
  logic [31:0]       rd;
  logic [31:0]       c1;
  int                errors;
  int                num_checks;
  int                pulses;
  int                cyc;
  int                w;

  wdt_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sys_in(sys_in), .sys_out(sys_out),
    .irq(irq));

  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  // Ceiling: one interrupt period, one protect period, plus margin
  always @(posedge pclk) begin
    cyc++;
    if (sys_out.irq === 1'h1) pulses++;
    if (cyc == 110000) begin
      errors++;
      final_report();
    end
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Prescaler phase makes counter reads approximate
  task automatic chk_near(input logic [31:0] got, input logic [31:0] exp, input int tol);
    num_checks++;
    if ($isunknown(got) || got > exp + tol || got + tol < exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_near

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 100);
    rd = prdata;
    perr = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic rg(input logic [11:0] a);
    apb(1'h0, a, 32'h0);
  endtask : rg

  task automatic endt(input string s);
    $display("test %s done", s);
  endtask : endt

  function automatic logic [31:0] exp_cnt(input int cycles, input int div);
    return 32'h0000_7FFF - 32'(cycles / div);
  endfunction : exp_cnt

  task automatic run_div(input int div);
    w = 100 + int'($urandom % 100) * (div / 16 + 1);
    apb(1'h1, wdt_pkg::OFS_RESTART, $urandom);
    repeat (w) @(posedge pclk);
    rg(wdt_pkg::OFS_COUNT);
    chk_near(rd, exp_cnt(w + 2, div), 2);
  endtask : run_div

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sys_in = '0;
    errors = 0;
    num_checks = 0;
    pulses = 0;
    cyc = 0;
    void'($urandom(94));
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    rg(wdt_pkg::OFS_COUNT);
    chk(rd, 32'h0);
    repeat (300) @(posedge pclk);
    rg(wdt_pkg::OFS_COUNT);
    chk(rd, 32'h0);
    rg(12'h100);
    chk({rd[30:0], perr}, 32'h1);
    apb(1'h1, wdt_pkg::OFS_MODE_TWO, 32'h4);
    rg(wdt_pkg::OFS_MODE_TWO);
    chk(rd, 32'h0);
    endt("reset");
    run_div(16);
    apb(1'h1, wdt_pkg::OFS_CONTROL, 32'h80);
    run_div(128);
    sys_in.sub_clk_cpu <= 1'h1;
    run_div(2);
    endt("divide");
    apb(1'h1, wdt_pkg::OFS_CLK_ONE, 32'h1);
    @(negedge pclk);
    chk({31'h0, sys_out.stop_active}, 32'h1);
    for (int m = 0; m < 2; m++) begin
      sys_in.stop_mode <= (m == 0);
      sys_in.wait_mode <= (m == 1);
      repeat (2) @(posedge pclk);
      rg(wdt_pkg::OFS_COUNT);
      c1 = rd;
      repeat (200) @(posedge pclk);
      rg(wdt_pkg::OFS_COUNT);
      chk(rd, c1);
    end
    sys_in.wait_mode <= 1'h0;
    repeat (20) @(posedge pclk);
    rg(wdt_pkg::OFS_COUNT);
    chk_near(rd, c1 - 32'd11, 3);
    chk({31'h0, sys_out.stop_active}, 32'h0);
    endt("freeze");
    apb(1'h1, wdt_pkg::OFS_IRQ_EN, 32'h1);
    apb(1'h1, wdt_pkg::OFS_RESTART, $urandom);
    apb(1'h1, wdt_pkg::OFS_IRQ_CLR, 32'h3);
    pulses = 0;
    repeat (65400) @(posedge pclk);
    chk(pulses, 32'h0);
    repeat (200) @(posedge pclk);
    chk(pulses, 32'h1);
    chk({30'h0, irq, sys_out.wdt_reset}, 32'h2);
    rg(wdt_pkg::OFS_COUNT);
    chk_near(rd, 32'h7FFF - 32'd35, 10);
    rg(wdt_pkg::OFS_IRQ_STAT);
    chk(rd & 32'h1, 32'h1);
    apb(1'h1, wdt_pkg::OFS_IRQ_EN, 32'h0);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'h1, wdt_pkg::OFS_IRQ_EN, 32'h1);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, wdt_pkg::OFS_IRQ_CLR, 32'h1);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    endt("interrupt");
    sys_in.sub_clk_cpu <= 1'h0;
    apb(1'h1, wdt_pkg::OFS_PROTECT, 32'h2);
    apb(1'h1, wdt_pkg::OFS_MODE_ONE, 32'h4);
    apb(1'h1, wdt_pkg::OFS_MODE_ONE, 32'h0);
    rg(wdt_pkg::OFS_MODE_ONE);
    chk(rd, 32'h4);
    apb(1'h1, wdt_pkg::OFS_MODE_TWO, 32'h4);
    apb(1'h1, wdt_pkg::OFS_PROTECT, 32'h0);
    apb(1'h1, wdt_pkg::OFS_MODE_TWO, 32'h0);
    rg(wdt_pkg::OFS_MODE_TWO);
    chk(rd, 32'h4);
    apb(1'h1, wdt_pkg::OFS_RESTART, $urandom);
    apb(1'h1, wdt_pkg::OFS_CLK_ONE, 32'h1);
    @(negedge pclk);
    chk({30'h0, sys_out.osc_run, sys_out.stop_active}, 32'h2);
    sys_in.wait_mode <= 1'h1;
    w = 20 + int'($urandom % 40);
    repeat (w) begin
      @(posedge pclk);
      sys_in.osc_tick <= 1'h1;
      @(posedge pclk);
      sys_in.osc_tick <= 1'h0;
    end
    rg(wdt_pkg::OFS_COUNT);
    chk_near(rd, exp_cnt(w, 1), 1);
    sys_in.osc_tick <= 1'h1;
    repeat (32800) @(posedge pclk);
    chk({pulses[30:0], sys_out.wdt_reset}, 32'h3);
    endt("protect");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
